/* File: verilog/rpm_pkg.sv */
`default_nettype none
package rpm_pkg;

  // Pin and field geometry
  localparam int unsigned RPM_NUM_PINS  = 26;
  localparam int unsigned RPM_SEL_W     = 5;
  localparam int unsigned RPM_NUM_INSEL = 14;
  localparam int unsigned RPM_INSEL_IDX_W = 4;
  localparam int unsigned RPM_PIN_IDX_W   = 5;

  // Input selector indices, one per remappable peripheral input
  localparam logic [3:0] RPM_IN_EXT_IRQ1   = 4'h0;
  localparam logic [3:0] RPM_IN_EXT_IRQ2   = 4'h1;
  localparam logic [3:0] RPM_IN_TMR2_CLK   = 4'h2;
  localparam logic [3:0] RPM_IN_TMR3_CLK   = 4'h3;
  localparam logic [3:0] RPM_IN_CAP_CH1    = 4'h4;
  localparam logic [3:0] RPM_IN_CAP_CH2    = 4'h5;
  localparam logic [3:0] RPM_IN_CAP_CH7    = 4'h6;
  localparam logic [3:0] RPM_IN_CAP_CH8    = 4'h7;
  localparam logic [3:0] RPM_IN_CMP_FAULTA = 4'h8;
  localparam logic [3:0] RPM_IN_UART_RX    = 4'h9;
  localparam logic [3:0] RPM_IN_UART_CTS   = 4'ha;
  localparam logic [3:0] RPM_IN_SPI_DATA   = 4'hb;
  localparam logic [3:0] RPM_IN_SPI_CLK    = 4'hc;
  localparam logic [3:0] RPM_IN_SPI_SEL    = 4'hd;

  // Output selector codes
  localparam logic [4:0] RPM_OUT_NULL     = 5'h00;
  localparam logic [4:0] RPM_OUT_UART_TX  = 5'h03;
  localparam logic [4:0] RPM_OUT_UART_RTS = 5'h04;
  localparam logic [4:0] RPM_OUT_SPI_DATA = 5'h07;
  localparam logic [4:0] RPM_OUT_SPI_CLK  = 5'h08;
  localparam logic [4:0] RPM_OUT_SPI_SEL  = 5'h09;
  localparam logic [4:0] RPM_OUT_CMP_CH1  = 5'h12;
  localparam logic [4:0] RPM_OUT_CMP_CH2  = 5'h13;

  // Reset values
  localparam logic [4:0] RPM_SEL_RST  = 5'h00;
  localparam logic       RPM_LOCK_RST = 1'b0;

  // Oscillator control low byte keys and lock bit position
  localparam logic [7:0] RPM_KEY1     = 8'h46;
  localparam logic [7:0] RPM_KEY2     = 8'h57;
  localparam int unsigned RPM_LOCK_BIT = 6;

  // Peripheral outputs that can be routed to a pin
  typedef struct packed {
    logic uart_transmit_out;
    logic uart_request_to_send_out;
    logic spi_data_out;
    logic spi_clock_out;
    logic spi_select_out;
    logic compare_ch1_out;
    logic compare_ch2_out;
  } rpm_periph_out_t;

  // Peripheral inputs fed from the pins
  typedef struct packed {
    logic ext_irq1_in;
    logic ext_irq2_in;
    logic timer2_ext_clock_in;
    logic timer3_ext_clock_in;
    logic capture_ch1_in;
    logic capture_ch2_in;
    logic capture_ch7_in;
    logic capture_ch8_in;
    logic compare_fault_a_in;
    logic uart_receive_in;
    logic uart_clear_to_send_in;
    logic spi_data_in;
    logic spi_clock_in;
    logic spi_select_in;
  } rpm_periph_in_t;

  // Register write port: byte write of oscillator control low byte,
  // selector writes by index
  typedef struct packed {
    logic       osc_wr;
    logic [7:0] osc_data;
    logic       in_wr;
    logic [3:0] in_idx;
    logic [4:0] in_data;
    logic       out_wr;
    logic [4:0] out_idx;
    logic [4:0] out_data;
  } rpm_wr_t;

  typedef enum logic [2:0] {
    RPM_ST_IDLE = 3'b001,
    RPM_ST_KEY1 = 3'b010,
    RPM_ST_KEY2 = 3'b100
  } rpm_state_t;

endpackage : rpm_pkg
`default_nettype wire

/* File: verilog/rpm_pin_mux.sv */
// Functional notes
// - Up to 26 remappable pins, numbered n
// - Five-bit input selector routes pin n
// - Input selectors for the fourteen listed peripheral inputs
// - Five-bit output selector per pin
// - Output code zero leaves port logic
// - Codes 3,4 route UART transmit, RTS
// - Codes 7,8,9 route SPI data, clock, select
// - Codes 18,19 route compare channels 1,2
// - Remap overrides digital, never analog
// - No interlock between selector fields
// - No default pin without assignment; here input selectors reset to code 0, pin 0
// - Locked selector writes silently ignored
// - Keys 46h then 57h unlock bit
// - Lock holds until next keyed change
// - Shadow mismatch raises configuration reset
// - One-way option blocks clearing set lock
// - One-way active when option unprogrammed
// - Input code n selects pin n
// - Reset disconnects outputs, lock unlocked
`timescale 1ns/10ps
`default_nettype none
module rpm_pin_mux
  import rpm_pkg::*;
#(
  parameter int unsigned NUM_PINS = RPM_NUM_PINS
) (
  input  wire logic                  sys_clk,            // System clock, 250 MHz
  input  wire logic                  rst_n,              // Async reset, active low
  input  wire rpm_wr_t               wr,                 // Register write port
  input  wire logic                  one_way_lock_option, // 1 = unprogrammed, one session
  input  wire logic [NUM_PINS-1:0]   pin_in,             // Remappable pin input levels
  input  wire logic [NUM_PINS-1:0]   pin_analog,         // Pin configured analog
  input  wire logic [NUM_PINS-1:0]   port_out,           // Default port data
  input  wire logic [NUM_PINS-1:0]   port_oe_n,          // Default port enable, low drives
  input  wire rpm_periph_out_t       periph_out,         // Peripheral output levels
  input  wire rpm_periph_out_t       periph_oe,          // Peripheral actively driving
  input  wire logic [NUM_PINS-1:0]   cell_upset,         // Fault hook: flips selector bit 0
  output rpm_periph_in_t             periph_in,          // Routed peripheral inputs
  output logic [NUM_PINS-1:0]        pin_out,            // Pin data
  output logic [NUM_PINS-1:0]        pin_oe_n,           // Pin drive enable, low drives
  output logic                       map_lock_bit,       // Map lock state
  output logic [7:0]                 osc_ctrl_low,       // Oscillator control low byte view
  output logic                       cfg_mismatch_rst    // Configuration mismatch reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [RPM_SEL_W-1:0] in_sel_r    [RPM_NUM_INSEL];
  logic [RPM_SEL_W-1:0] in_shadow_r [RPM_NUM_INSEL];

  logic [RPM_SEL_W-1:0] out_sel_r    [NUM_PINS];
  logic [RPM_SEL_W-1:0] out_shadow_r [NUM_PINS];

  logic                 map_lock_r;
  logic                 lock_set_once_r;
  logic                 mismatch_r;

  rpm_state_t           state_r;
  rpm_state_t           state_nxt;
  logic                 lock_upd;
  logic                 lock_nxt;
  logic                 sel_wr_ok;
  logic [NUM_PINS-1:0]  mis_out;
  logic [RPM_NUM_INSEL-1:0] mis_in;
  logic                 mis_any;

  // Write strobes decoded once; sequencer, lock and selectors share them
  logic                 any_sel_wr;
  logic                 key1_seen;
  logic                 key2_seen;
  logic                 lock_write;
  logic                 clear_refused;
  logic [RPM_NUM_INSEL-1:0] in_hit;
  logic [NUM_PINS-1:0]  out_hit;
  logic [RPM_NUM_INSEL-1:0] in_route;
  logic [NUM_PINS-1:0]  remap_drv;
  logic [NUM_PINS-1:0]  remap_val;
  logic [NUM_PINS-1:0]  remap_ok;

  // Pin n picked by a selector; codes past the last pin read low
  function automatic logic pick_pin(input logic [NUM_PINS-1:0] pins,
                                    input logic [RPM_SEL_W-1:0] sel);
    logic r;
    r = 1'b0;
    if (32'(sel) < NUM_PINS) begin
      r = pins[sel];
    end
    return r;
  endfunction

  // Drive flag of the peripheral a pin's code names; null and unused codes give 0
  function automatic logic out_active(input rpm_periph_out_t e,
                                      input logic [RPM_SEL_W-1:0] sel);
    logic r;
    r = 1'b0;
    unique case (sel)
      RPM_OUT_UART_TX:  r = e.uart_transmit_out;
      RPM_OUT_UART_RTS: r = e.uart_request_to_send_out;
      RPM_OUT_SPI_DATA: r = e.spi_data_out;
      RPM_OUT_SPI_CLK:  r = e.spi_clock_out;
      RPM_OUT_SPI_SEL:  r = e.spi_select_out;
      RPM_OUT_CMP_CH1:  r = e.compare_ch1_out;
      RPM_OUT_CMP_CH2:  r = e.compare_ch2_out;
      default:          r = 1'b0;
    endcase
    return r;
  endfunction

  // Data level of the peripheral a pin's code names
  function automatic logic out_level(input rpm_periph_out_t d,
                                     input logic [RPM_SEL_W-1:0] sel);
    logic r;
    r = 1'b0;
    unique case (sel)
      RPM_OUT_UART_TX:  r = d.uart_transmit_out;
      RPM_OUT_UART_RTS: r = d.uart_request_to_send_out;
      RPM_OUT_SPI_DATA: r = d.spi_data_out;
      RPM_OUT_SPI_CLK:  r = d.spi_clock_out;
      RPM_OUT_SPI_SEL:  r = d.spi_select_out;
      RPM_OUT_CMP_CH1:  r = d.compare_ch1_out;
      RPM_OUT_CMP_CH2:  r = d.compare_ch2_out;
      default:          r = 1'b0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  assign any_sel_wr = wr.in_wr || wr.out_wr;
  assign key1_seen  = wr.osc_wr && (wr.osc_data == RPM_KEY1);
  assign key2_seen  = wr.osc_wr && (wr.osc_data == RPM_KEY2);
  assign lock_write = wr.osc_wr;

  // One strobe per selector keeps the update loops free of index compares
  always_comb begin
    for (int i = 0; i < RPM_NUM_INSEL; i++) begin
      in_hit[i] = wr.in_wr && sel_wr_ok && (32'(wr.in_idx) == i);
    end

    for (int i = 0; i < NUM_PINS; i++) begin
      out_hit[i] = wr.out_wr && sel_wr_ok && (32'(wr.out_idx) == i);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Unlock key sequence

  always_comb begin
    state_nxt = state_r;
    lock_upd  = 1'b0;

    unique case (state_r)
      RPM_ST_IDLE: begin
        if (key1_seen) begin
          state_nxt = RPM_ST_KEY1;
        end
      end

      // A selector write in the same cycle as the second key or the update write counts as intervening
      RPM_ST_KEY1: begin
        if (any_sel_wr || (lock_write && !key2_seen)) begin
          state_nxt = RPM_ST_IDLE;
        end else if (key2_seen) begin
          state_nxt = RPM_ST_KEY2;
        end
      end

      RPM_ST_KEY2: begin
        if (any_sel_wr) begin
          state_nxt = RPM_ST_IDLE;
        end else if (lock_write) begin
          lock_upd  = 1'b1;
          state_nxt = RPM_ST_IDLE;
        end
      end

      default: begin
        state_nxt = RPM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RPM_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Map lock

  // Clearing is refused once set while the one-way option is unprogrammed
  assign clear_refused = one_way_lock_option && lock_set_once_r;

  always_comb begin
    lock_nxt = wr.osc_data[RPM_LOCK_BIT];
    if (clear_refused) begin
      lock_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_lock_r      <= RPM_LOCK_RST;
      lock_set_once_r <= 1'b0;
    end else if (lock_upd) begin
      map_lock_r      <= lock_nxt;
      lock_set_once_r <= lock_set_once_r | lock_nxt;
    end
  end

  assign map_lock_bit = map_lock_r;
  assign osc_ctrl_low = {1'b0, map_lock_r, 6'h00};
  assign sel_wr_ok    = !map_lock_r;

  ////////////////////////////////////////////////////////////////////////////
  // Selectors and shadows; shadows follow only legitimate writes

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < RPM_NUM_INSEL; i++) begin
        in_sel_r[i]    <= RPM_SEL_RST;
        in_shadow_r[i] <= RPM_SEL_RST;
      end
    end else begin
      for (int i = 0; i < RPM_NUM_INSEL; i++) begin
        if (in_hit[i]) begin
          in_sel_r[i]    <= wr.in_data;
          in_shadow_r[i] <= wr.in_data;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        out_sel_r[i]    <= RPM_SEL_RST;
        out_shadow_r[i] <= RPM_SEL_RST;
      end
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (out_hit[i]) begin
          out_sel_r[i]    <= wr.out_data;
          out_shadow_r[i] <= wr.out_data;
        end else if (cell_upset[i]) begin
          // Models a disturbed storage cell; the shadow is left alone
          out_sel_r[i][0] <= ~out_sel_r[i][0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Continuous state monitoring

  always_comb begin
    for (int i = 0; i < RPM_NUM_INSEL; i++) begin
      mis_in[i] = in_sel_r[i] != in_shadow_r[i];
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      mis_out[i] = out_sel_r[i] != out_shadow_r[i];
    end
  end

  assign mis_any = (|mis_in) || (|mis_out);

  // Sticky: stands until the system reset it requests is applied
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mismatch_r <= 1'b0;
    end else if (mis_any) begin
      mismatch_r <= 1'b1;
    end
  end

  assign cfg_mismatch_rst = mismatch_r;

  ////////////////////////////////////////////////////////////////////////////
  // Input routing; every input has its own selector, so sharing pins is free

  always_comb begin
    for (int i = 0; i < RPM_NUM_INSEL; i++) begin
      in_route[i] = pick_pin(pin_in, in_sel_r[i]);
    end
  end

  always_comb begin
    periph_in.ext_irq1_in           = in_route[RPM_IN_EXT_IRQ1];
    periph_in.ext_irq2_in           = in_route[RPM_IN_EXT_IRQ2];
    periph_in.timer2_ext_clock_in   = in_route[RPM_IN_TMR2_CLK];
    periph_in.timer3_ext_clock_in   = in_route[RPM_IN_TMR3_CLK];
    periph_in.capture_ch1_in        = in_route[RPM_IN_CAP_CH1];
    periph_in.capture_ch2_in        = in_route[RPM_IN_CAP_CH2];
    periph_in.capture_ch7_in        = in_route[RPM_IN_CAP_CH7];
    periph_in.capture_ch8_in        = in_route[RPM_IN_CAP_CH8];
    periph_in.compare_fault_a_in    = in_route[RPM_IN_CMP_FAULTA];
    periph_in.uart_receive_in       = in_route[RPM_IN_UART_RX];
    periph_in.uart_clear_to_send_in = in_route[RPM_IN_UART_CTS];
    periph_in.spi_data_in           = in_route[RPM_IN_SPI_DATA];
    periph_in.spi_clock_in          = in_route[RPM_IN_SPI_CLK];
    periph_in.spi_select_in         = in_route[RPM_IN_SPI_SEL];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output routing per pin analog pins are never taken over

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      remap_drv[i] = out_active(periph_oe, out_sel_r[i]);
      remap_val[i] = out_level(periph_out, out_sel_r[i]);
    end
  end

  // Analog pins keep their port path even when a peripheral is mapped
  assign remap_ok = remap_drv & ~pin_analog;

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (remap_ok[i]) begin
        pin_out[i]  = remap_val[i];
        pin_oe_n[i] = 1'b0;
      end else begin
        pin_out[i]  = port_out[i];
        pin_oe_n[i] = port_oe_n[i];
      end
    end
  end

endmodule : rpm_pin_mux
`default_nettype wire

/* File: tb/rpm_pin_mux_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module rpm_pin_mux_chk
  import rpm_pkg::*;
#(
  parameter int unsigned NUM_PINS = RPM_NUM_PINS
) (
  input wire logic                sys_clk,             // Clock
  input wire logic                rst_n,               // Reset
  input wire rpm_wr_t             wr,                  // Writes
  input wire logic                one_way_lock_option, // One session
  input wire logic [NUM_PINS-1:0] pin_in,              // Pads
  input wire logic [NUM_PINS-1:0] pin_analog,          // Analog
  input wire logic [NUM_PINS-1:0] port_out,            // Port data
  input wire logic [NUM_PINS-1:0] port_oe_n,           // Port enable
  input wire logic [NUM_PINS-1:0] cell_upset,          // Upset hook
  input wire rpm_periph_in_t      periph_in,           // Routed inputs
  input wire logic [NUM_PINS-1:0] pin_out,             // Pad data
  input wire logic [NUM_PINS-1:0] pin_oe_n,            // Pad enable
  input wire logic                map_lock_bit,        // Lock
  input wire logic                cfg_mismatch_rst     // Mismatch
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic in_done_r;
  logic out_done_r;
  // Reset-state checks only hold until the first selector write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) in_done_r <= 1'b0;
    else if (wr.in_wr) in_done_r <= 1'b1;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) out_done_r <= 1'b0;
    else if (wr.out_wr) out_done_r <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  sequence s_key(logic [7:0] k);
    wr.osc_wr && wr.osc_data == k && !wr.in_wr && !wr.out_wr;
  endsequence
  sequence s_unlock;
    s_key(RPM_KEY1) ##1 s_key(RPM_KEY2) ##1 (wr.osc_wr && !wr.in_wr && !wr.out_wr);
  endsequence
  key_update_a : assert property (
    s_unlock |=> map_lock_bit == $past(wr.osc_data[RPM_LOCK_BIT]) || $past(map_lock_bit))
    else $error("keyed lock update not applied");
  lock_cause_a : assert property (
    $changed(map_lock_bit) |-> $past(wr.osc_wr) && $past(wr.osc_data[RPM_LOCK_BIT]) == map_lock_bit)
    else $error("lock changed without an update write");
  one_way_a : assert property (
    one_way_lock_option && $past(one_way_lock_option) && $past(map_lock_bit) |-> map_lock_bit)
    else $error("lock cleared under one-way option");
  upset_trip_a : assert property (
    |cell_upset |-> ##2 cfg_mismatch_rst)
    else $error("upset did not raise mismatch reset");
  mm_sticky_a : assert property (
    cfg_mismatch_rst |=> cfg_mismatch_rst [*3])
    else $error("mismatch reset dropped");
  mm_quiet_a : assert property (
    !cfg_mismatch_rst && cell_upset == '0 |=> !cfg_mismatch_rst || $past(cell_upset, 2) != '0)
    else $error("mismatch reset without upset");
  in_reset_a : assert property (
    !in_done_r |-> periph_in == rpm_periph_in_t'({14{pin_in[0]}}))
    else $error("inputs not on pin zero after reset");
  out_null_a : assert property (
    !out_done_r |-> pin_out == port_out && pin_oe_n == port_oe_n)
    else $error("pin not on port logic after reset");
  analog_keep_a : assert property (
    |pin_analog |-> ((pin_out ^ port_out) & pin_analog) == '0 && ((pin_oe_n ^ port_oe_n) & pin_analog) == '0)
    else $error("remap drove an analog pin");
endmodule // rpm_pin_mux_chk
bind rpm_pin_mux rpm_pin_mux_chk #(.NUM_PINS(NUM_PINS)) u_chk (
  .sys_clk, .rst_n, .wr, .one_way_lock_option, .pin_in, .pin_analog, .port_out,
  .port_oe_n, .cell_upset, .periph_in, .pin_out, .pin_oe_n, .map_lock_bit, .cfg_mismatch_rst
);
`default_nettype wire

/* File: tb/rpm_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rpm_far_model
  import rpm_pkg::*;
(
  input wire logic                    sys_clk, // Clock
  output logic [RPM_NUM_PINS-1:0]     pins,    // Pad levels
  output rpm_periph_out_t             po,      // Peripheral data
  output rpm_periph_out_t             poe      // Peripheral driving
);
  // Fresh random levels every cycle so a stale route cannot keep matching by luck for long
  initial {pins, po, poe} = '0;
  always @(posedge sys_clk) begin
    pins <= RPM_NUM_PINS'($urandom);
    po   <= 7'($urandom);
    poe  <= 7'($urandom);
  end
endmodule // rpm_far_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench
  import rpm_pkg::*;
;
  localparam int NP = RPM_NUM_PINS;
  logic            sys_clk = 1'b0;
  logic            rst_n   = 1'b0;
  logic            ow      = 1'b0;
  rpm_wr_t         wr      = '0;
  logic [NP-1:0]   an = '0, pto = '0, ptn = '1, ups = '0, pin_in, pout, poen;
  rpm_periph_out_t po, poe;
  rpm_periph_in_t  pi;
  logic            lk, mm, rlk, ronce, rmm;
  logic [7:0]      ocl;
  logic [4:0]      isel [14];
  logic [4:0]      osel [NP];
  logic [4:0]      codes [8] = '{5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h12, 5'h13, 5'h00};
  int              st, failures = 0, check_count = 0;
  logic [75:0]     exq [$];

  always #2 sys_clk = ~sys_clk;
  rpm_far_model u_far (.sys_clk, .pins(pin_in), .po, .poe);
  rpm_pin_mux #(.NUM_PINS(NP)) u_dut (
    .sys_clk, .rst_n, .wr, .one_way_lock_option(ow), .pin_in, .pin_analog(an),
    .port_out(pto), .port_oe_n(ptn), .periph_out(po), .periph_oe(poe), .cell_upset(ups),
    .periph_in(pi), .pin_out(pout), .pin_oe_n(poen), .map_lock_bit(lk),
    .osc_ctrl_low(ocl), .cfg_mismatch_rst(mm));
  ////////////////////////////////////////////////////////////////////
  task check(input logic [75:0] got, input logic [75:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t outputs %h expected %h", $time, got, exp);
    end
  endtask
  task conclude();
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [75:0] expect_now();
    logic [13:0]   ei;
    logic [NP-1:0] eo, en;
    int            k;
    for (int j = 0; j < 14; j++)
      ei[13-j] = (isel[j] < NP) ? pin_in[isel[j]] : 1'b0;
    for (int i = 0; i < NP; i++) begin
      case (osel[i])
        5'h03: k = 6;
        5'h04: k = 5;
        5'h07: k = 4;
        5'h08: k = 3;
        5'h09: k = 2;
        5'h12: k = 1;
        5'h13: k = 0;
        default: k = -1;
      endcase
      eo[i] = (k >= 0 && poe[k] && !an[i]) ? po[k] : pto[i];
      en[i] = (k >= 0 && poe[k] && !an[i]) ? 1'b0 : ptn[i];
    end
    return {ei, eo, en, rlk, 1'b0, rlk, 6'h00, rmm};
  endfunction
  // Mirror of the lock sequencer, applied at the edge that drives the write, one edge before the design takes it
  function automatic void take(input rpm_wr_t w);
    if (w.in_wr && !rlk && w.in_idx < 14) isel[w.in_idx] = w.in_data;
    if (w.out_wr && !rlk && w.out_idx < NP) osel[w.out_idx] = w.out_data;
    if (st == 1) begin
      st = (w.in_wr || w.out_wr || (w.osc_wr && w.osc_data != 8'h57)) ? 0 : (w.osc_wr ? 2 : 1);
    end else if (st == 2 && (w.in_wr || w.out_wr)) begin
      st = 0;
    end else if (st == 2 && w.osc_wr) begin
      if (!(ow && ronce && !w.osc_data[6])) rlk = w.osc_data[6];
      ronce = ronce | rlk;
      st = 0;
    end else if (st == 0 && w.osc_wr && w.osc_data == 8'h46) begin
      st = 1;
    end
  endfunction
  task drv(input rpm_wr_t w);
    @(posedge sys_clk);
    wr  <= w;
    pto <= NP'($urandom);
    ptn <= NP'($urandom);
    an  <= NP'($urandom);
    take(w);
  endtask
  task snap();
    drv('0);
    #1 exq.push_back(expect_now());
  endtask
  task osc(input logic [7:0] d);
    rpm_wr_t w;
    w = '0;
    {w.osc_wr, w.osc_data} = {1'b1, d};
    drv(w);
  endtask
  task sw(input logic o, input int idx, input int d);
    rpm_wr_t w;
    w = '0;
    if (o) {w.out_wr, w.out_idx, w.out_data} = {1'b1, 5'(idx), 5'(d)};
    else {w.in_wr, w.in_idx, w.in_data} = {1'b1, 4'(idx), 5'(d)};
    drv(w);
  endtask
  task lock(input logic b);
    osc(8'h46);
    osc(8'h57);
    osc({1'b0, b, 6'h00});
    snap();
  endtask
  task rst();
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (isel[j]) isel[j] = '0;
    foreach (osel[j]) osel[j] = '0;
    {rlk, ronce, rmm} = '0;
    st = 0;
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk) begin
    if (exq.size() != 0)
      check({pi, pout, poen, lk, ocl, mm}, exq.pop_front());
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    conclude();
  end
  initial begin
    void'($urandom(15));
    rst();
    snap();
    for (int i = 0; i < 60; i++) begin
      sw(1'b0, $urandom % 16, $urandom % 32);
      sw(1'b1, $urandom % 32, (i < 8) ? codes[i] : 5'($urandom));
      snap();
    end
    lock(1'b1);
    sw(1'b0, 1, 5);
    sw(1'b1, 2, 3);
    snap();
    osc(8'h46);
    sw(1'b0, 0, 0);
    osc(8'h57);
    osc(8'h00);
    osc(8'h46);
    osc(8'h46);
    osc(8'h57);
    osc(8'h00);
    snap();
    lock(1'b0);
    sw(1'b0, 3, 7);
    sw(1'b1, 4, 8);
    sw(1'b1, 5, 9);
    snap();
    lock(1'b1);
    @(posedge sys_clk) ow <= 1'b1;
    lock(1'b0);
    @(posedge sys_clk) ups <= 26'h8;
    @(posedge sys_clk) ups <= '0;
    osel[3][0] = ~osel[3][0];
    rmm = 1'b1;
    snap();
    snap();
    rst();
    snap();
    for (int n = 0; n < 8 && exq.size() != 0; n++) @(posedge sys_clk);
    if (exq.size() != 0) failures++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
